// ### design/aos_device.sv
// Device end: offset compensation, self-test deflection and autosleep link
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
module aos_device #(
    parameter int RATE_DIV = 16
) (
    input wire logic clock,
    input wire logic reset,
    aos_link_if.device link,
    input wire logic [3*aos_pkg::SAMPLE_W-1:0] raw_sample,
    input wire logic raw_valid,
    input wire logic activity_seen,
    input wire logic inactivity_seen,
    output logic data_ready,
    output logic activity_irq,
    output logic inactivity_irq,
    output logic asleep
);
    import aos_pkg::*;

    // One-hot: awake samples at the host rate, sleep at the fixed slow code
    typedef enum logic [1:0] {
        AOS_AWAKE = 2'b01,
        AOS_SLEEP = 2'b10
    } aos_state_type;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] offset_trim [3];
    logic [7:0] output_rate_and_power;
    logic [7:0] output_format_control;
    logic [7:0] power_ctl;
    logic [7:0] int_enable;
    logic [7:0] int_source;
    logic [15:0] data_out [3];
    aos_state_type state;
    logic [7:0] rate_count;
    logic [7:0] rdata_q;
    logic rvalid_q;

    // Offset scaled to output resolution: x4 in full resolution, else by range
    // The shift must be arithmetic so a negative trim stays negative; in the
    // coarsest range (code 3) an odd trim loses its last half step to the shift
    function automatic logic [15:0] scale_offset(input logic [7:0] ofs,
                                                 input logic [7:0] fmt);
        logic signed [15:0] ext;
        ext = {{8{ofs[7]}}, ofs}; // R13
        if (fmt[FMT_FULL_RES]) begin
            scale_offset = ext <<< 2; // R6
        end else begin
            scale_offset = (ext <<< 2) >>> fmt[1:0]; // R5
        end
    endfunction : scale_offset

    ////////////////////////////////////////////////////////////////////////
    wire wr_hit = link.write;
    wire rd_source = link.read && (link.addr == REG_INT_SOURCE);
    wire link_mode = power_ctl[PWR_LINK] && power_ctl[PWR_AUTO_SLEEP];
    wire act_pending = int_source[INT_ACTIVITY];
    // Event qualifiers: an event only counts while its enable is set
    wire act_event = activity_seen && int_enable[INT_ACTIVITY];
    wire inact_event = inactivity_seen && int_enable[INT_INACTIVITY];
    // A pending activity event blocks sleep until software reads the source
    wire go_sleep = (state == AOS_AWAKE) && link_mode && inact_event && !act_pending; // R12
    wire wake = (state == AOS_SLEEP) && act_event; // R2
    // Sleep forces the slow code; the host's rate register is left untouched,
    // so waking restores the configured rate with nothing to copy back
    wire [3:0] div_code = (state == AOS_SLEEP) ? SLEEP_RATE_CODE // R1
        : output_rate_and_power[3:0];
    // Only code bits 3:2 shorten the divider; finer codes share a rate
    wire [7:0] div_limit = 8'(RATE_DIV) >> div_code[3:2];
    // Low power keeps ticking; only sleep changes the rate
    wire tick = raw_valid && (rate_count >= div_limit); // R3
    wire [7:0] next_rate_count = tick ? 8'h00 : rate_count + 8'h01;
    wire self_test = output_format_control[FMT_SELF_TEST];

    ////////////////////////////////////////////////////////////////////////
    // Per-axis compensation; the sum wraps in 16 bits like the output word
    logic [15:0] comp_sample [3];
    for (genvar g = 0; g < 3; g++) begin : gen_axis
        wire [15:0] raw_axis = raw_sample[g*SAMPLE_W +: SAMPLE_W];
        wire [15:0] trim_axis = scale_offset(offset_trim[g], output_format_control); // R13
        wire [15:0] shift_axis = self_test ? SELF_TEST_SHIFT : 16'h0000; // R8
        assign comp_sample[g] = raw_axis + trim_axis + shift_axis; // R4
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read selection; unmapped addresses read zero
    logic [7:0] read_mux;
    always_comb begin
        unique case (link.addr)
            REG_X_OFFSET: read_mux = offset_trim[0];
            REG_Y_OFFSET: read_mux = offset_trim[1];
            REG_Z_OFFSET: read_mux = offset_trim[2];
            REG_RATE: read_mux = output_rate_and_power;
            REG_POWER_CTL: read_mux = power_ctl;
            REG_INT_ENABLE: read_mux = int_enable;
            REG_INT_SOURCE: read_mux = int_source;
            REG_FORMAT: read_mux = output_format_control;
            REG_DATA_X: read_mux = data_out[0][7:0];
            REG_DATA_Y: read_mux = data_out[1][7:0];
            REG_DATA_Z: read_mux = data_out[2][7:0];
            REG_STATUS: read_mux = {7'h00, state == AOS_SLEEP};
            default: read_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes and autosleep enable swaps
    // A same-cycle swap overrides a host write to the two detect enables
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < 3; i++) offset_trim[i] <= OFFSET_RESET; // R7
            output_rate_and_power <= RATE_RESET;
            output_format_control <= FORMAT_RESET;
            power_ctl <= 8'h00;
            int_enable <= 8'h00;
            state <= AOS_AWAKE;
        end else begin
            if (wr_hit) begin
                unique case (link.addr)
                    REG_X_OFFSET: offset_trim[0] <= link.wdata; // R4
                    REG_Y_OFFSET: offset_trim[1] <= link.wdata;
                    REG_Z_OFFSET: offset_trim[2] <= link.wdata;
                    REG_RATE: output_rate_and_power <= link.wdata;
                    REG_POWER_CTL: power_ctl <= link.wdata;
                    REG_INT_ENABLE: int_enable <= link.wdata;
                    REG_FORMAT: output_format_control <= link.wdata; // R8
                    default: ;
                endcase
            end
            if (go_sleep) begin
                state <= AOS_SLEEP; // R1
                int_enable[INT_INACTIVITY] <= 1'b0; // R1
                int_enable[INT_ACTIVITY] <= 1'b1; // R1
            end else if (wake) begin
                state <= AOS_AWAKE; // R2
                int_enable[INT_ACTIVITY] <= 1'b0; // R2
                int_enable[INT_INACTIVITY] <= 1'b1; // R2
            end
        end
    end

    // Pending events: set wins over the clearing read
    // A source read clears every pending bit at once
    always_ff @(posedge clock) begin
        if (reset) begin
            int_source <= 8'h00;
        end else begin
            int_source <= rd_source ? 8'h00 : int_source; // R12
            if (act_event) begin
                int_source[INT_ACTIVITY] <= 1'b1; // R2
            end
            if (inact_event) begin
                int_source[INT_INACTIVITY] <= 1'b1; // R12
            end
            if (tick) begin
                int_source[INT_DATA_READY] <= 1'b1; // R3
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate divider and compensated samples
    // The divider counts raw pulses, so a stalled raw stream stalls the output
    always_ff @(posedge clock) begin
        if (reset) begin
            rate_count <= 8'h00;
            for (int i = 0; i < 3; i++) data_out[i] <= 16'h0000;
        end else if (raw_valid) begin
            rate_count <= next_rate_count;
            if (tick) begin
                for (int i = 0; i < 3; i++) data_out[i] <= comp_sample[i]; // R4
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path, one cycle latency; data registers give the low byte
    // rvalid follows read by exactly one edge; the host never overlaps reads
    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= link.read;
            rdata_q <= read_mux;
        end
    end

    // Registered outputs
    // Pins copy the pending bits a cycle late; software still reads the source
    always_ff @(posedge clock) begin
        if (reset) begin
            data_ready <= 1'b0;
            activity_irq <= 1'b0;
            inactivity_irq <= 1'b0;
            asleep <= 1'b0;
            link.sample_tick <= 1'b0;
        end else begin
            data_ready <= int_source[INT_DATA_READY];
            activity_irq <= int_source[INT_ACTIVITY];
            inactivity_irq <= int_source[INT_INACTIVITY];
            asleep <= (state == AOS_SLEEP);
            link.sample_tick <= tick;
        end
    end

    assign link.rdata = rdata_q;
    assign link.rvalid = rvalid_q;
endmodule : aos_device

// ### design/aos_host.sv
// Host end: Avalon-MM command registers driving the device register link
`timescale 1ns/100ps
module aos_host (
    input wire logic clock,
    input wire logic reset,
    aos_link_if.host link,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import aos_pkg::*;

    typedef enum logic [2:0] {
        AOS_IDLE = 3'b001,
        AOS_ISSUE = 3'b010,
        AOS_WAIT = 3'b100
    } aos_hstate_type;

    ////////////////////////////////////////////////////////////////////////
    aos_hstate_type state;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] read_data;
    logic [2:0] settle_count;
    logic busy;
    logic cmd_write;

    // Writing the format register with self-test set restarts settle count
    wire st_enable = (cmd_addr == REG_FORMAT) && cmd_write
        && link.wdata[FMT_SELF_TEST];
    wire settled = (settle_count == 3'(SETTLE_SAMPLES));
    wire take = !avs_waitrequest && (avs_read || avs_write);
    wire start_wr = take && avs_write && (avs_address == HREG_CMD_DATA);
    wire start_rd = take && avs_write && (avs_address == HREG_CMD_ADDR)
        && avs_writedata[8];

    ////////////////////////////////////////////////////////////////////////
    // Link transaction sequencer
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= AOS_IDLE;
            cmd_addr <= '0;
            cmd_write <= 1'b0;
            link.addr <= '0;
            link.wdata <= '0;
            link.write <= 1'b0;
            link.read <= 1'b0;
            read_data <= '0;
            busy <= 1'b0;
        end else begin
            link.write <= 1'b0;
            link.read <= 1'b0;
            unique case (state)
                AOS_IDLE: begin
                    if (take && avs_write && avs_address == HREG_CMD_ADDR) begin
                        cmd_addr <= avs_writedata[ADDR_W-1:0];
                    end
                    if (start_wr) begin
                        link.addr <= cmd_addr;
                        link.wdata <= avs_writedata[7:0]; // R8
                        link.write <= 1'b1;
                        cmd_write <= 1'b1;
                        busy <= 1'b1;
                        state <= AOS_ISSUE;
                    end else if (start_rd) begin
                        link.addr <= avs_writedata[ADDR_W-1:0];
                        link.read <= 1'b1;
                        cmd_write <= 1'b0;
                        busy <= 1'b1;
                        state <= AOS_WAIT;
                    end
                end
                AOS_ISSUE: begin
                    busy <= 1'b0;
                    cmd_write <= 1'b0;
                    state <= AOS_IDLE;
                end
                AOS_WAIT: begin
                    if (link.rvalid) begin
                        read_data <= link.rdata;
                        busy <= 1'b0;
                        state <= AOS_IDLE;
                    end
                end
            endcase
        end
    end

    // Count samples after self-test enable so software skips them
    always_ff @(posedge clock) begin
        if (reset) begin
            settle_count <= 3'(SETTLE_SAMPLES);
        end else if (st_enable && state == AOS_ISSUE) begin
            settle_count <= 3'h0; // R11
        end else if (link.sample_tick && !settled) begin
            settle_count <= settle_count + 3'h1; // R11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle per access, then the answer
    always_ff @(posedge clock) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
            if (avs_read && avs_waitrequest) begin
                unique case (avs_address)
                    HREG_CMD_ADDR: avs_readdata <= {26'h0, cmd_addr};
                    HREG_STATUS: avs_readdata <= {30'h0, settled, busy};
                    HREG_READ_DATA: avs_readdata <= {24'h0, read_data};
                    HREG_SETTLE: avs_readdata <= {29'h0, settle_count};
                    default: avs_readdata <= HOST_UNMAPPED;
                endcase
            end
        end
    end
endmodule : aos_host

// ### pkg/aos_link_if.sv
// Interface: parallel register link between host and accelerometer readout
`timescale 1ns/100ps
interface aos_link_if;
    import aos_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic write;
    logic read;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic sample_tick;
    modport device (input addr, input wdata, input write, input read,
        output rdata, output rvalid, output sample_tick);
    modport host (output addr, output wdata, output write, output read,
        input rdata, input rvalid, input sample_tick);
endinterface : aos_link_if

// ### pkg/aos_pkg.sv
// Package: register map, fields and timing for the accelerometer readout path
// Function
// R1: Autosleep with link: inactivity drops rate, swaps enables
// R2: Activity in sleep restores rate, swaps enables back
// R3: Low power keeps data-ready and buffer working
// R4: Three signed 8-bit offsets added per axis
// R5: Offset step fixed, independent of range
// R6: Full resolution: offset scaled by four
// R7: Offsets reset to zero
// R8: Format bit D7 enables self-test deflection
// R9: Host sets valid rate, low power cleared
// R10: Host sets full resolution, 16 g range
// R11: Host discards four settling samples
// R12: Activity/inactivity pending until source read
// R13: Offset sign-extended and scaled to resolution
package aos_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 16;
    // Device register offsets
    localparam logic [5:0] REG_X_OFFSET = 6'h1E;
    localparam logic [5:0] REG_Y_OFFSET = 6'h1F;
    localparam logic [5:0] REG_Z_OFFSET = 6'h20;
    localparam logic [5:0] REG_RATE = 6'h2C;
    localparam logic [5:0] REG_POWER_CTL = 6'h2D;
    localparam logic [5:0] REG_INT_ENABLE = 6'h2E;
    localparam logic [5:0] REG_INT_SOURCE = 6'h30;
    localparam logic [5:0] REG_FORMAT = 6'h31;
    localparam logic [5:0] REG_DATA_X = 6'h32;
    localparam logic [5:0] REG_DATA_Y = 6'h33;
    localparam logic [5:0] REG_DATA_Z = 6'h34;
    localparam logic [5:0] REG_STATUS = 6'h35;
    // Field positions
    localparam int FMT_SELF_TEST = 7;
    localparam int FMT_FULL_RES = 3;
    localparam int RATE_LOW_POWER = 4;
    localparam int PWR_LINK = 5;
    localparam int PWR_AUTO_SLEEP = 4;
    localparam int INT_DATA_READY = 7;
    localparam int INT_ACTIVITY = 4;
    localparam int INT_INACTIVITY = 3;
    localparam int STAT_ASLEEP = 0;
    // Reset values
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic [7:0] RATE_RESET = 8'h0A;
    localparam logic [7:0] FORMAT_RESET = 8'h00;
    localparam logic [3:0] SLEEP_RATE_CODE = 4'h2;
    // Self-test shift added per axis, in output steps
    localparam logic [15:0] SELF_TEST_SHIFT = 16'h0040;
    // Host side: samples to discard after self-test enable
    localparam int SETTLE_SAMPLES = 4;
    // Host Avalon register offsets (word index = byte/4)
    localparam logic [3:0] HREG_CMD_ADDR = 4'h0;
    localparam logic [3:0] HREG_CMD_DATA = 4'h1;
    localparam logic [3:0] HREG_STATUS = 4'h2;
    localparam logic [3:0] HREG_READ_DATA = 4'h3;
    localparam logic [3:0] HREG_SETTLE = 4'h4;
    localparam logic [31:0] HOST_UNMAPPED = 32'h0000_0000;
endpackage : aos_pkg

// ### verification/aos_link_monitor.sv
// Checker: link handshake and register readback between host and device
`timescale 1ns/100ps
module aos_link_monitor (
    input wire logic clock,
    input wire logic reset,
    input wire logic [aos_pkg::ADDR_W-1:0] addr,
    input wire logic [aos_pkg::DATA_W-1:0] wdata,
    input wire logic write,
    input wire logic read,
    input wire logic [aos_pkg::DATA_W-1:0] rdata,
    input wire logic rvalid,
    input wire logic sample_tick
);
    import aos_pkg::*;
    logic [7:0] sh_x;
    logic [7:0] sh_y;
    logic [7:0] sh_z;
    logic [7:0] sh_fmt;
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the offset and format registers; a dropped write shows at the next read
    always_ff @(posedge clock) begin
        if (reset) begin
            sh_x <= 8'h00;
            sh_y <= 8'h00;
            sh_z <= 8'h00;
            sh_fmt <= FORMAT_RESET;
        end else if (write) begin
            if (addr == REG_X_OFFSET) sh_x <= wdata;
            if (addr == REG_Y_OFFSET) sh_y <= wdata;
            if (addr == REG_Z_OFFSET) sh_z <= wdata;
            if (addr == REG_FORMAT) sh_fmt <= wdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // One clock domain, so clocking and reset are given once
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    AST_READ_ANSWER: assert property (read |=> rvalid)
        else $error("link read not answered in the next cycle");
    AST_NO_STRAY_VALID: assert property (rvalid |-> $past(read))
        else $error("read valid without a read one cycle before");
    AST_X_OFFSET_READ: assert property (read && addr == REG_X_OFFSET |=> rdata == sh_x)
        else $error("x offset readback differs from last write");
    AST_Y_OFFSET_READ: assert property (read && addr == REG_Y_OFFSET ##1 rvalid |-> rdata == sh_y)
        else $error("y offset readback differs from last write");
    AST_Z_OFFSET_READ: assert property (rvalid && $past(addr) == REG_Z_OFFSET |-> rdata == sh_z)
        else $error("z offset readback differs from last write");
    AST_FORMAT_READ: assert property (read && addr == REG_FORMAT |=> rdata == sh_fmt)
        else $error("format readback differs from last write");
    AST_UNMAPPED_ZERO: assert property (read && addr == 6'h00 |=> rvalid && rdata == 8'h00)
        else $error("unmapped device address did not read zero");
    AST_RESET_QUIET: assert property ($fell(reset) |-> !rvalid && !sample_tick)
        else $error("link outputs active at reset release");
endmodule : aos_link_monitor

// ### verification/tb_top.sv
// Testbench: host and device joined by the link, driven over Avalon-MM
`timescale 1ns/100ps
module tb_top;
    import aos_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [47:0] raw_sample = 48'h0000_0000_0000;
    logic raw_valid = 1'b0;
    logic activity_seen = 1'b0;
    logic inactivity_seen = 1'b0;
    logic data_ready, activity_irq, inactivity_irq, asleep;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    logic [63:0] exp_q [$];
    logic [63:0] q;
    logic [31:0] rd;
    logic [47:0] s;
    logic [7:0] off [3] = '{8'hFD, 8'h03, 8'hFE};
    logic [7:0] codes [5] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0F};
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////
    // Both ends face each other; the checker watches the link between them
    aos_link_if aos_link_if_i ();
    aos_device #(.RATE_DIV(8)) aos_device_i (.clock(clock), .reset(reset),
        .link(aos_link_if_i), .raw_sample(raw_sample), .raw_valid(raw_valid),
        .activity_seen(activity_seen), .inactivity_seen(inactivity_seen),
        .data_ready(data_ready), .activity_irq(activity_irq),
        .inactivity_irq(inactivity_irq), .asleep(asleep));
    aos_host aos_host_i (.clock(clock), .reset(reset), .link(aos_link_if_i),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    aos_link_monitor aos_link_monitor_i (.clock(clock), .reset(reset),
        .addr(aos_link_if_i.addr), .wdata(aos_link_if_i.wdata),
        .write(aos_link_if_i.write), .read(aos_link_if_i.read),
        .rdata(aos_link_if_i.rdata), .rvalid(aos_link_if_i.rvalid),
        .sample_tick(aos_link_if_i.sample_tick));
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    // Hang guard: the whole sequence needs well under two thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    // Watcher: each completed read takes the oldest note; mask zero means poll
    always @(posedge clock) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            q = exp_q.pop_front();
            if (q[63:32] != 32'h0000_0000) begin
                checked++;
                if ((avs_readdata & q[63:32]) !== q[31:0]) begin
                    n_mismatch++;
                    $display("CHECK FAILED %0t got %h exp %h", $time, avs_readdata, q[31:0]);
                end
            end
        end
    end
    task automatic pin(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : pin
    ////////////////////////////////////////////////////////////////////////////
    // Avalon cycle: request held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [31:0] e);
        @(posedge clock);
        if (!wr) exp_q.push_back({m, e});
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : av
    task automatic lwait();
        do av(1'b0, HREG_STATUS, 32'h0, 32'h0, 32'h0); while (rd[0] !== 1'b0);
    endtask : lwait
    task automatic lwr(input logic [5:0] a, input logic [7:0] d);
        av(1'b1, HREG_CMD_ADDR, {26'h0, a}, 32'h0, 32'h0);
        av(1'b1, HREG_CMD_DATA, {24'h0, d}, 32'h0, 32'h0);
        lwait();
    endtask : lwr
    task automatic lrd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
        av(1'b1, HREG_CMD_ADDR, {23'h0, 1'b1, 2'h0, a}, 32'h0, 32'h0);
        lwait();
        av(1'b0, HREG_READ_DATA, 32'h0, {24'h0, m}, {24'h0, e});
    endtask : lrd
    // Raw pulses every other cycle until the device reports a new sample
    task automatic smp();
        @(posedge clock);
        raw_sample <= s;
        raw_valid <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            @(posedge clock);
            if (aos_link_if_i.sample_tick === 1'b1 || i == 23) break;
            raw_valid <= !raw_valid;
        end
        raw_valid <= 1'b0;
        s = {16'($urandom()), $urandom()};
        // Outputs launched at the last edge are looked at only once settled
        @(negedge clock);
    endtask : smp
    function automatic logic [7:0] expv(input logic [15:0] raw, input logic [7:0] o,
                                        input int sh, input logic st);
        logic signed [15:0] sc;
        sc = $signed({{8{o[7]}}, o}) <<< 2;
        sc = sc >>> sh;
        return 8'(raw + sc + (st ? SELF_TEST_SHIFT : 16'h0000));
    endfunction : expv
    task automatic chk3(input int sh, input logic st, input logic [47:0] v);
        for (int j = 0; j < 3; j++) lrd(6'(REG_DATA_X + j), 8'hFF, expv(v[16*j +: 16], off[j], sh, st));
    endtask : chk3
    task automatic ev(input logic act);
        @(posedge clock);
        activity_seen <= act;
        inactivity_seen <= !act;
        @(posedge clock);
        activity_seen <= 1'b0;
        inactivity_seen <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : ev
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: offsets, scaling, self-test, low power, autosleep
    initial begin
        logic [47:0] v;
        void'($urandom(95714));
        s = {16'($urandom()), $urandom()};
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        av(1'b0, 4'hF, 32'h0, 32'hFFFF_FFFF, 32'h0000_0000);
        lrd(6'h00, 8'hFF, 8'h00);
        for (int j = 0; j < 3; j++) lrd(6'(REG_X_OFFSET + j), 8'hFF, 8'h00);
        for (int j = 0; j < 3; j++) lwr(6'(REG_X_OFFSET + j), off[j]);
        for (int j = 0; j < 3; j++) lrd(6'(REG_X_OFFSET + j), 8'hFF, off[j]);
        for (int i = 0; i < 5; i++) begin
            lwr(REG_FORMAT, (i < 4) ? 8'(i) : 8'h0B);
            v = s;
            smp();
            chk3((i < 4) ? i : 0, 1'b0, v);
        end
        lwr(REG_FORMAT, 8'h8B);
        av(1'b0, HREG_STATUS, 32'h0, 32'h2, 32'h0);
        for (int i = 0; i < 5; i++) begin
            lwr(REG_RATE, codes[i]);
            v = s;
            smp();
            chk3(0, 1'b1, v);
        end
        av(1'b0, HREG_STATUS, 32'h0, 32'h2, 32'h2);
        av(1'b0, HREG_SETTLE, 32'h0, 32'h7, 32'h4);
        lwr(REG_FORMAT, 8'h0B);
        v = s;
        smp();
        chk3(0, 1'b0, v);
        lwr(REG_RATE, 8'h1A);
        lwr(REG_INT_ENABLE, 8'h88);
        lrd(REG_INT_SOURCE, 8'h80, 8'h80);
        pin(data_ready, 1'b0);
        smp();
        pin(data_ready, 1'b1);
        lrd(REG_INT_SOURCE, 8'h80, 8'h80);
        pin(data_ready, 1'b0);
        lwr(REG_RATE, 8'h0A);
        lwr(REG_POWER_CTL, 8'h30);
        ev(1'b0);
        pin(asleep, 1'b1);
        pin(inactivity_irq, 1'b1);
        lrd(REG_INT_ENABLE, 8'h18, 8'h10);
        lrd(REG_STATUS, 8'h01, 8'h01);
        lrd(REG_INT_SOURCE, 8'h18, 8'h08);
        pin(inactivity_irq, 1'b0);
        ev(1'b1);
        pin(asleep, 1'b0);
        pin(activity_irq, 1'b1);
        lrd(REG_INT_ENABLE, 8'h18, 8'h08);
        lrd(REG_RATE, 8'hFF, 8'h0A);
        ev(1'b0);
        pin(asleep, 1'b0);
        lrd(REG_INT_SOURCE, 8'h10, 8'h10);
        ev(1'b0);
        pin(asleep, 1'b1);
        complete_run();
    end
endmodule : tb_top
